// file: hw/phy_mgmt_defines.vh
// Offsets, field positions, reset values and timing counts of the management registers
`ifndef PHY_MGMT_DEFINES_VH
`define PHY_MGMT_DEFINES_VH

// ==========================================================
// Register indices
`define REG_BASIC_CONTROL      5'h00
`define REG_BASIC_STATUS       5'h01
`define REG_IDENTIFIER_HIGH    5'h02
`define REG_IDENTIFIER_LOW     5'h03

// ==========================================================
// Control word fields
`define CTL_SOFT_RESET         15
`define CTL_LOOPBACK           14
`define CTL_SPEED_100          13
`define CTL_AUTONEG_EN         12
`define CTL_POWER_DOWN         11
`define CTL_ISOLATE            10
`define CTL_AUTONEG_RESTART    9
`define CTL_FULL_DUPLEX        8

// ==========================================================
// Status word fields
`define STS_T4_ABLE            15
`define STS_TX_FD_ABLE         14
`define STS_TX_HD_ABLE         13
`define STS_T_FD_ABLE          12
`define STS_T_HD_ABLE          11
`define STS_T2_FD_ABLE         10
`define STS_T2_HD_ABLE         9
`define STS_EXT_STATUS         8
`define STS_AUTONEG_DONE       5
`define STS_REMOTE_FAULT       4
`define STS_AUTONEG_ABLE       3
`define STS_LINK_UP            2
`define STS_JABBER             1
`define STS_EXT_CAPABLE        0

// ==========================================================
// Identifier low word fields
`define ID_ORG_MSB             15
`define ID_ORG_LSB             10
`define ID_MODEL_MSB           9
`define ID_MODEL_LSB           4
`define ID_REV_MSB             3
`define ID_REV_LSB             0

// ==========================================================
// Reset values
`define RST_LOOPBACK           1'b0
`define RST_POWER_DOWN         1'b0
`define RST_ISOLATE            1'b0
`define RST_FLAG               1'b0
`define RST_LOW_LATCH_EVENT    1'b1
`define RST_RDATA              16'h0000

// ==========================================================
// Timing
`define CLOCK_PERIOD_NS        5
`define SOFT_RESET_TIME_NS     100
`define SOFT_RESET_CYCLES      ((`SOFT_RESET_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SOFT_RESET_CNT_W       5

`endif

// file: hw/latch_flag.v
// Read-cleared latching status flag, latch-high or latch-low
`timescale 1ns/1ps
`include "phy_mgmt_defines.vh"

module latch_flag #(
  parameter LATCH_LOW = 0
) (
  input  wire clock,
  input  wire reset_n,
  input  wire clear,
  input  wire condition,
  input  wire read_pulse,
  output wire flag
);

  // ==========================================================
  // Latch storage, held in latch-high sense
  reg  event_r;
  wire event_in;
  wire event_nxt;

  assign event_in  = LATCH_LOW ? ~condition : condition;
  // Event wins over the read that clears it
  assign event_nxt = event_in | (event_r & ~read_pulse);

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // Latch-low flag reads zero from reset
      event_r <= LATCH_LOW ? `RST_LOW_LATCH_EVENT : `RST_FLAG;
    end else if (clear) begin
      event_r <= event_in;
    end else begin
      event_r <= event_nxt;
    end
  end

  assign flag = LATCH_LOW ? ~event_r : event_r;

endmodule // latch_flag

// file: hw/phy_basic_mgmt_registers.v
// Basic control, status and identifier registers of a 10/100 transceiver
//
// How it works
// - control bit 15 starts reset, self-clears
// - soft reset keeps speed, auto-negotiation and duplex bits, clears bits 14, 11, 10 and 9
// - bit 14 loopback, resets to zero
// - bit 13 speed, ignored under auto-negotiation
// - bit 12 enables auto-negotiation, overrides manual
// - bit 11 power down, resets to zero
// - bit 10 isolates from RMII, resets zero
// - bit 9 restarts auto-negotiation, self-clears
// - bit 8 duplex, ignored under auto-negotiation
// - straps give defaults; bits 7:0 reserved
// - status 14:11 ones; 15,10,9 zeros
// - status 8 zero; 7:6 reserved
// - status 5 shows auto-negotiation done
// - status 4 remote fault latches high
// - status 2 link latches low, resets zero
// - status 1 jabber latches high, resets zero
// - status 3 and 0 read one
// - first identifier word, writable organization bits
// - second word: organization, model, revision
// - latch-high drops after read if cause gone
`timescale 1ns/1ps
`include "phy_mgmt_defines.vh"

module phy_basic_mgmt_registers #(
  // Identifier defaults below are arbitrary neutral values
  parameter [15:0] ORG_ID_HIGH_DEFAULT = 16'h0A5C,
  parameter [5:0]  ORG_ID_LOW_DEFAULT  = 6'h15,
  parameter [5:0]  MODEL_DEFAULT       = 6'h2A,
  parameter [3:0]  REVISION_DEFAULT    = 4'h1
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rdata_valid,
  input  wire        strap_speed_100,
  input  wire        strap_autoneg_en,
  input  wire        strap_full_duplex,
  input  wire        link_up,
  input  wire        remote_fault,
  input  wire        jabber,
  input  wire        autoneg_done,
  input  wire        autoneg_speed_100,
  input  wire        autoneg_full_duplex,
  output wire        soft_reset,
  output wire        loopback,
  output wire        speed_100,
  output wire        full_duplex,
  output wire        autoneg_enable,
  output wire        autoneg_restart,
  output wire        power_down,
  output wire        isolate
);

  // ==========================================================
  // Decode of register accesses
  wire wr_ctl;
  wire wr_id_high;
  wire wr_id_low;
  wire rd_status;

  assign wr_ctl     = reg_wr_en & (reg_addr == `REG_BASIC_CONTROL);
  assign wr_id_high = reg_wr_en & (reg_addr == `REG_IDENTIFIER_HIGH);
  assign wr_id_low  = reg_wr_en & (reg_addr == `REG_IDENTIFIER_LOW);
  assign rd_status  = reg_rd_en & (reg_addr == `REG_BASIC_STATUS);

  // ==========================================================
  // Strap capture after reset release
  reg straps_taken_r;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      straps_taken_r <= 1'b0;
    end else begin
      straps_taken_r <= 1'b1;
    end
  end

  // ==========================================================
  // Software reset sequencer
  reg  [`SOFT_RESET_CNT_W-1:0] srst_cnt_r;
  reg  [`SOFT_RESET_CNT_W-1:0] srst_cnt_nxt;
  reg                          srst_r;
  reg                          srst_nxt;
  wire                         srst_start;
  wire                         srst_end;
  wire [31:0]                  srst_load = `SOFT_RESET_CYCLES - 1;

  assign srst_start = wr_ctl & reg_wdata[`CTL_SOFT_RESET] & ~srst_r;
  assign srst_end   = srst_r & (srst_cnt_r == {`SOFT_RESET_CNT_W{1'b0}});

  always @* begin
    srst_nxt     = srst_r;
    srst_cnt_nxt = srst_cnt_r;
    if (srst_start) begin
      srst_nxt     = 1'b1;
      srst_cnt_nxt = srst_load[`SOFT_RESET_CNT_W-1:0];
    end else if (srst_end) begin
      srst_nxt     = 1'b0;
    end else if (srst_r) begin
      srst_cnt_nxt = srst_cnt_r - 1'b1;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      srst_r     <= 1'b0;
      srst_cnt_r <= {`SOFT_RESET_CNT_W{1'b0}};
    end else begin
      srst_r     <= srst_nxt;
      srst_cnt_r <= srst_cnt_nxt;
    end
  end

  assign soft_reset = srst_r;

  // ==========================================================
  // Control word storage
  reg loopback_r;
  reg speed_100_r;
  reg autoneg_en_r;
  reg power_down_r;
  reg isolate_r;
  reg restart_r;
  reg full_duplex_r;
  wire ctl_write_ok;

  // The host keeps other bits clear when it sets reset
  assign ctl_write_ok = wr_ctl & ~reg_wdata[`CTL_SOFT_RESET] & ~srst_r;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      loopback_r    <= `RST_LOOPBACK;
      power_down_r  <= `RST_POWER_DOWN;
      isolate_r     <= `RST_ISOLATE;
      speed_100_r   <= 1'b0;
      autoneg_en_r  <= 1'b0;
      full_duplex_r <= 1'b0;
      restart_r     <= 1'b0;
    end else if (!straps_taken_r) begin
      speed_100_r   <= strap_speed_100;
      autoneg_en_r  <= strap_autoneg_en;
      full_duplex_r <= strap_full_duplex;
    end else if (srst_start) begin
      // Speed, negotiation and duplex keep their current values
      loopback_r    <= `RST_LOOPBACK;
      power_down_r  <= `RST_POWER_DOWN;
      isolate_r     <= `RST_ISOLATE;
      restart_r     <= 1'b0;
    end else if (ctl_write_ok) begin
      loopback_r    <= reg_wdata[`CTL_LOOPBACK];
      speed_100_r   <= reg_wdata[`CTL_SPEED_100];
      autoneg_en_r  <= reg_wdata[`CTL_AUTONEG_EN];
      power_down_r  <= reg_wdata[`CTL_POWER_DOWN];
      isolate_r     <= reg_wdata[`CTL_ISOLATE];
      restart_r     <= reg_wdata[`CTL_AUTONEG_RESTART];
      full_duplex_r <= reg_wdata[`CTL_FULL_DUPLEX];
    end else begin
      restart_r     <= 1'b0;
    end
  end

  // ==========================================================
  // Operating configuration
  assign loopback        = loopback_r;
  assign autoneg_enable  = autoneg_en_r;
  assign speed_100       = autoneg_en_r ? autoneg_speed_100 : speed_100_r;
  assign full_duplex     = autoneg_en_r ? autoneg_full_duplex : full_duplex_r;
  assign autoneg_restart = restart_r;
  assign power_down      = power_down_r;
  assign isolate         = isolate_r;

  // ==========================================================
  // Latched status flags
  wire remote_fault_flag;
  wire link_flag;
  wire jabber_flag;

  latch_flag #(
    .LATCH_LOW  (0)
  ) u_remote_fault (
    .clock      (clock),
    .reset_n    (reset_n),
    .clear      (srst_start),
    .condition  (remote_fault),
    .read_pulse (rd_status),
    .flag       (remote_fault_flag)
  );

  latch_flag #(
    .LATCH_LOW  (1)
  ) u_link (
    .clock      (clock),
    .reset_n    (reset_n),
    .clear      (1'b0),
    .condition  (link_up),
    .read_pulse (rd_status),
    .flag       (link_flag)
  );

  latch_flag #(
    .LATCH_LOW  (0)
  ) u_jabber (
    .clock      (clock),
    .reset_n    (reset_n),
    .clear      (srst_start),
    .condition  (jabber),
    .read_pulse (rd_status),
    .flag       (jabber_flag)
  );

  // ==========================================================
  // Identifier words
  reg [15:0] id_high_r;
  reg [15:0] id_low_r;
  reg        id_loaded_r;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      id_high_r   <= 16'h0000;
      id_low_r    <= 16'h0000;
      id_loaded_r <= 1'b0;
    end else if (!id_loaded_r) begin
      id_high_r   <= ORG_ID_HIGH_DEFAULT;
      id_low_r    <= {ORG_ID_LOW_DEFAULT, MODEL_DEFAULT, REVISION_DEFAULT};
      id_loaded_r <= 1'b1;
    end else begin
      if (wr_id_high) begin
        id_high_r <= reg_wdata;
      end
      if (wr_id_low) begin
        id_low_r  <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Assembled read words
  reg [15:0] ctl_word;
  reg [15:0] sts_word;

  always @* begin
    ctl_word                       = 16'h0000;
    ctl_word[`CTL_SOFT_RESET]      = srst_r;
    ctl_word[`CTL_LOOPBACK]        = loopback_r;
    ctl_word[`CTL_SPEED_100]       = speed_100_r;
    ctl_word[`CTL_AUTONEG_EN]      = autoneg_en_r;
    ctl_word[`CTL_POWER_DOWN]      = power_down_r;
    ctl_word[`CTL_ISOLATE]         = isolate_r;
    ctl_word[`CTL_AUTONEG_RESTART] = restart_r;
    ctl_word[`CTL_FULL_DUPLEX]     = full_duplex_r;
  end

  always @* begin
    sts_word                     = 16'h0000;
    sts_word[`STS_TX_FD_ABLE]    = 1'b1;
    sts_word[`STS_TX_HD_ABLE]    = 1'b1;
    sts_word[`STS_T_FD_ABLE]     = 1'b1;
    sts_word[`STS_T_HD_ABLE]     = 1'b1;
    sts_word[`STS_AUTONEG_DONE]  = autoneg_done;
    sts_word[`STS_REMOTE_FAULT]  = remote_fault_flag;
    sts_word[`STS_AUTONEG_ABLE]  = 1'b1;
    sts_word[`STS_LINK_UP]       = link_flag;
    sts_word[`STS_JABBER]        = jabber_flag;
    sts_word[`STS_EXT_CAPABLE]   = 1'b1;
  end

  // ==========================================================
  // Registered read port
  reg [15:0] rdata_nxt;

  always @* begin
    case (reg_addr)
      `REG_BASIC_CONTROL:   rdata_nxt = ctl_word;
      `REG_BASIC_STATUS:    rdata_nxt = sts_word;
      `REG_IDENTIFIER_HIGH: rdata_nxt = id_high_r;
      `REG_IDENTIFIER_LOW:  rdata_nxt = id_low_r;
      default:              rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata       <= `RST_RDATA;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

endmodule // phy_basic_mgmt_registers

// file: bench/phy_mgmt_properties.sv
// Concurrent checks on the management register ports
`timescale 1ns/1ps
`include "phy_mgmt_defines.vh"

module phy_mgmt_properties (
  input logic        clock,
  input logic        reset_n,
  input logic [4:0]  reg_addr,
  input logic        reg_wr_en,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input logic        reg_rdata_valid,
  input logic        autoneg_speed_100,
  input logic        autoneg_full_duplex,
  input logic        soft_reset,
  input logic        loopback,
  input logic        speed_100,
  input logic        full_duplex,
  input logic        autoneg_enable,
  input logic        autoneg_restart,
  input logic        power_down,
  input logic        isolate
);
  // ==========
  // Helpers
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire ctl_wr = reg_wr_en && reg_addr == `REG_BASIC_CONTROL && !soft_reset;
  wire cfg_wr = ctl_wr && !reg_wdata[`CTL_SOFT_RESET];

  sequence soft_run;
    ##1 soft_reset [*8] ##12 soft_reset ##1 !soft_reset;
  endsequence

  // ==========
  // Properties
  chk_soft_length: assert property (
    ctl_wr && reg_wdata[`CTL_SOFT_RESET] |-> soft_run) else $error("soft reset length");
  chk_soft_clears: assert property (
    $fell(soft_reset) |-> !loopback && !power_down && !isolate) else $error("soft reset clear");
  chk_restart_pulse: assert property (
    cfg_wr && reg_wdata[`CTL_AUTONEG_RESTART] |=> autoneg_restart ##1 !autoneg_restart)
    else $error("restart pulse");
  chk_loopback_write: assert property (
    cfg_wr |=> loopback == $past(reg_wdata[`CTL_LOOPBACK])) else $error("loopback");
  chk_power_write: assert property (
    cfg_wr |=> power_down == $past(reg_wdata[`CTL_POWER_DOWN])) else $error("power down");
  chk_isolate_write: assert property (
    cfg_wr |=> isolate == $past(reg_wdata[`CTL_ISOLATE])) else $error("isolate");
  chk_autoneg_write: assert property (
    cfg_wr |=> autoneg_enable == $past(reg_wdata[`CTL_AUTONEG_EN])) else $error("autoneg");
  chk_autoneg_override: assert property (
    autoneg_enable |-> speed_100 == autoneg_speed_100 && full_duplex == autoneg_full_duplex)
    else $error("autoneg override");
  chk_status_fixed: assert property (
    reg_rdata_valid && $past(reg_addr) == `REG_BASIC_STATUS
    |-> reg_rdata[15:8] == 8'h78 && reg_rdata[3] && reg_rdata[0]) else $error("status fixed");
  chk_control_reserved: assert property (
    reg_rdata_valid && $past(reg_addr) == `REG_BASIC_CONTROL |-> reg_rdata[7:0] == 8'h00)
    else $error("control reserved");
endmodule // phy_mgmt_properties

bind phy_basic_mgmt_registers phy_mgmt_properties chk (
  .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
  .autoneg_speed_100(autoneg_speed_100), .autoneg_full_duplex(autoneg_full_duplex),
  .soft_reset(soft_reset), .loopback(loopback), .speed_100(speed_100),
  .full_duplex(full_duplex), .autoneg_enable(autoneg_enable),
  .autoneg_restart(autoneg_restart), .power_down(power_down), .isolate(isolate)
);

// file: bench/mgmt_controller_model.sv
// Station management controller model on the register port
`timescale 1ns/1ps

module mgmt_controller_model (
  input  logic        clock,
  input  logic [15:0] reg_rdata,
  input  logic        reg_rdata_valid,
  output logic [4:0]  reg_addr,
  output logic        reg_wr_en,
  output logic        reg_rd_en,
  output logic [15:0] reg_wdata
);
  // ==========
  // Bus cycles
  initial begin
    reg_addr  = 5'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 16'h0000;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_wdata = (a == 5'h00 && d[15]) ? 16'h8000 : d;
    reg_wr_en = 1'b1;
    @(posedge clock);
    #1;
    reg_wr_en = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(posedge clock);
    #1;
    reg_rd_en = 1'b0;
    d = reg_rdata_valid ? reg_rdata : 16'hXXXX;
  endtask
endmodule // mgmt_controller_model

// file: bench/phy_basic_mgmt_registers_test.sv
// Self-checking bench for the basic management registers
`timescale 1ns/1ps

module phy_basic_mgmt_registers_test;
  logic        clock;
  logic        reset_n;
  logic [4:0]  reg_addr;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rdata_valid;
  logic [2:0]  strap;
  logic [5:0]  st;
  logic [7:0]  cfg;
  logic [15:0] rv;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;

  // ==========
  // Instances
  phy_basic_mgmt_registers uut (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .strap_speed_100(strap[2]),
    .strap_autoneg_en(strap[1]), .strap_full_duplex(strap[0]), .link_up(st[5]),
    .remote_fault(st[4]), .jabber(st[3]), .autoneg_done(st[2]),
    .autoneg_speed_100(st[1]), .autoneg_full_duplex(st[0]), .soft_reset(cfg[7]),
    .loopback(cfg[6]), .speed_100(cfg[5]), .full_duplex(cfg[4]),
    .autoneg_enable(cfg[3]), .autoneg_restart(cfg[2]), .power_down(cfg[1]),
    .isolate(cfg[0])
  );
  mgmt_controller_model mgmt (
    .clock(clock), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata)
  );

  // ==========
  // Helpers
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic rdchk(input string n, input logic [4:0] a, input logic [15:0] e);
    mgmt.rd(a, rv);
    check(n, e, rv);
  endtask

  task automatic finish_test();
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_defaults();
    rdchk("control", 5'h00, 16'h2100);
    rdchk("status", 5'h01, 16'h7809);
    rdchk("id high", 5'h02, 16'h0A5C);
    rdchk("id low", 5'h03, 16'h56A1);
    check("outputs", 16'h0030, {8'h00, cfg});
  endtask

  task automatic t_control();
    st = 6'b000001;
    mgmt.wr(5'h00, 16'h6CFF);
    check("outputs", 16'h0063, {8'h00, cfg});
    rdchk("control", 5'h00, 16'h6C00);
    mgmt.wr(5'h00, 16'h3200);
    check("outputs", 16'h001C, {8'h00, cfg});
    @(posedge clock);
    #1;
    check("restart", 16'h0000, {15'h0000, cfg[2]});
    rdchk("control", 5'h00, 16'h3000);
  endtask

  task automatic t_soft();
    int n;
    n = 0;
    mgmt.wr(5'h00, 16'h4000);
    mgmt.wr(5'h00, 16'h8000);
    while (cfg[7] === 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("soft length", 16'h0014, n[15:0]);
    rdchk("control", 5'h00, 16'h0000);
    check("outputs", 16'h0000, {8'h00, cfg});
  endtask

  task automatic t_latch();
    st = 6'b111101;
    @(posedge clock);
    #1;
    st = 6'b100101;
    rdchk("status", 5'h01, 16'h783B);
    rdchk("status", 5'h01, 16'h782D);
    st = 6'b000101;
    @(posedge clock);
    #1;
    st = 6'b101101;
    rdchk("status", 5'h01, 16'h782B);
    st = 6'b100101;
    rdchk("status", 5'h01, 16'h782F);
    rdchk("status", 5'h01, 16'h782D);
  endtask

  task automatic t_misc();
    mgmt.wr(5'h01, 16'h0000);
    rdchk("status", 5'h01, 16'h782D);
    mgmt.wr(5'h02, 16'h1234);
    rdchk("id high", 5'h02, 16'h1234);
    mgmt.wr(5'h03, 16'hFFFF);
    rdchk("id low", 5'h03, 16'hFFFF);
    rdchk("unmapped", 5'h1F, 16'h0000);
  endtask

  // ==========
  // Clock, watchdog and sequence
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    reset_n = 1'b0;
    strap = 3'b101;
    st = 6'b000000;
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    t_defaults();
    t_control();
    t_soft();
    t_latch();
    t_misc();
    finish_test();
  end
endmodule // phy_basic_mgmt_registers_test
